// ==== hw/uer_pkg.sv ====
// package: register map, field layout and reset values for the error register bank
package uer_pkg;
    localparam logic [11:0] UER_OFS_HEADER     = 12'h100;
    localparam logic [11:0] UER_OFS_STATUS     = 12'h104;
    localparam logic [11:0] UER_OFS_MASK       = 12'h108;
    localparam logic [11:0] UER_OFS_FIRST_PTR  = 12'h118;

    localparam logic [15:0] UER_CAP_ID         = 16'h0001;
    localparam logic [3:0]  UER_CAP_VERSION    = 4'h1;
    localparam logic [11:0] UER_NEXT_UP        = 12'h140;
    localparam logic [11:0] UER_NEXT_DOWN      = 12'h20c;
    localparam int          UER_ID_LSB         = 0;
    localparam int          UER_VER_LSB        = 16;
    localparam int          UER_NEXT_LSB       = 20;

    localparam int          UER_NUM_SRC        = 11;
    localparam int          UER_BIT_TRAIN      = 0;
    localparam int          UER_BIT_DLLP       = 4;
    localparam int          UER_BIT_POISON     = 12;
    localparam int          UER_BIT_FCPE       = 13;
    localparam int          UER_BIT_CTO        = 14;
    localparam int          UER_BIT_CABT       = 15;
    localparam int          UER_BIT_UNEXP      = 16;
    localparam int          UER_BIT_OVF        = 17;
    localparam int          UER_BIT_MALF       = 18;
    localparam int          UER_BIT_ECRC       = 19;
    localparam int          UER_BIT_UR         = 20;
    localparam logic [31:0] UER_IMPL_MASK      = 32'h001ff011;
    localparam logic [31:0] UER_STATUS_RST     = 32'h0000_0000;
    localparam logic [31:0] UER_MASK_RST       = 32'h0000_0000;
    localparam logic [4:0]  UER_PTR_RST        = 5'h00;
    localparam logic [1:0]  UER_RESP_OKAY      = 2'b00;
    localparam logic [1:0]  UER_RESP_SLVERR    = 2'b10;

    function automatic logic [4:0] uer_lowest_bit(input logic [31:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction
endpackage

// ==== hw/uer_evt_if.sv ====
// interface: error event vector and its gated message/log strobes
interface uer_evt_if;
    logic [31:0] evt;
    logic [31:0] mask;
    logic [31:0] report;
    modport src (output evt, output mask, input report);
    modport gate (input evt, input mask, output report);
endinterface

// ==== hw/uer_gate.sv ====
// module: mask gating of detected error events toward the first error pointer and messages
module uer_gate
    import uer_pkg::*;
(
    uer_evt_if.gate ev
);
    // masked classes never reach logging or the message path
    assign ev.report = ev.evt & ~ev.mask & UER_IMPL_MASK; // [RQ11] [RQ12] [RQ13] [RQ14]
endmodule // uer_gate

// ==== hw/uer_regs.sv ====
// module: error reporting capability header, uncorrectable status and mask over AXI4-Lite
// ---------------------------------------------------------------
// Summary of operation
// RQ1: the header low 16 bits read the fixed id 0001h and cannot be written.
// RQ2: header bits 19:16 read version 1h, which is also the reset value.
// RQ3: header bits 31:20 read next offset 140h upstream or 20Ch downstream.
// RQ4: status bit 0 sets on a link training error and resets to zero.
// RQ5: status bit 4 sets on a data link protocol error and resets to zero.
// RQ6: status bit 12 sets when a poisoned packet is received or generated.
// RQ7: status bit 13 sets on a flow control protocol error and resets to zero.
// RQ8: status bits 14, 15, 16 set on completion timeout, completer abort, unexpected completion.
// RQ9: status bits 17 and 18 set on receiver overflow and malformed packet.
// RQ10: status bits 19 and 20 set on end-to-end crc error and unsupported request.
// RQ11: mask bits 0 and 4 stop logging and messages for their errors; reset zero.
// RQ12: mask bits 12 and 13 stop logging and messages for their errors; reset zero.
// RQ13: mask bits 14 to 16 stop logging and messages for their errors; reset zero.
// RQ14: mask bits 17 to 20 stop logging and messages for their errors; reset zero.
// RQ15: status clears on write one, zero has no effect, reserved bits read zero.
// RQ16: a sticky 5-bit pointer holds the bit position of the first reported error.
// ---------------------------------------------------------------
module uer_regs
    import uer_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        sticky_nrst_i,
    input  wire logic        downstream_i,
    input  wire logic [31:0] err_event_i,
    output logic      [31:0] err_report_o,
    output logic      [4:0]  first_err_ptr_o,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // ---------------------------------------------------------------
    // reset synchronisers
    // ---------------------------------------------------------------
    logic        rst_meta_r;
    logic        rst_sync_r;
    logic        srst_meta_r;
    logic        srst_sync_r;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // sticky bits follow only the auxiliary reset, so hot resets keep the log
    always_ff @(posedge sys_clk_i or negedge sticky_nrst_i) begin
        if (!sticky_nrst_i) begin
            srst_meta_r <= 1'b0;
            srst_sync_r <= 1'b0;
        end else begin
            srst_meta_r <= 1'b1;
            srst_sync_r <= srst_meta_r;
        end
    end

    // ---------------------------------------------------------------
    // write channel
    // ---------------------------------------------------------------
    logic [11:0] aw_addr_r;
    logic        aw_have_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        w_have_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;

    wire         aw_fire  = s_axi_awvalid & s_axi_awready;
    wire         w_fire   = s_axi_wvalid & s_axi_wready;
    wire         wr_go    = aw_have_r & w_have_r & ~bvalid_r;
    wire [31:0]  wr_bmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                             {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    wire [31:0]  wr_bits  = w_data_r & wr_bmask;
    wire         wr_stat  = wr_go & (aw_addr_r == UER_OFS_STATUS);
    wire         wr_mask  = wr_go & (aw_addr_r == UER_OFS_MASK);
    wire         wr_ro    = (aw_addr_r == UER_OFS_HEADER) | (aw_addr_r == UER_OFS_FIRST_PTR);
    wire         wr_hit   = (aw_addr_r == UER_OFS_STATUS) | (aw_addr_r == UER_OFS_MASK) | wr_ro;

    assign s_axi_awready = ~aw_have_r;
    assign s_axi_wready  = ~w_have_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            aw_addr_r <= 12'h000;
            aw_have_r <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            w_have_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= UER_RESP_OKAY;
        end else begin
            if (aw_fire) begin
                aw_addr_r <= {s_axi_awaddr[11:2], 2'b00};
                aw_have_r <= 1'b1;
            end
            if (w_fire) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
            end
            if (wr_go) begin
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_hit ? UER_RESP_OKAY : UER_RESP_SLVERR;
                aw_have_r <= 1'b0;
                w_have_r  <= 1'b0;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // status, mask and first error pointer
    // ---------------------------------------------------------------
    logic [31:0] status_r;
    logic [31:0] mask_r;
    logic [4:0]  first_ptr_r;
    logic        ptr_valid_r;
    logic [31:0] status_nxt;
    logic [31:0] mask_nxt;

    uer_evt_if ev ();
    assign ev.evt  = err_event_i;
    assign ev.mask = mask_r;
    uer_gate u_gate (
        .ev (ev)
    );

    // event set wins over a same-cycle clear
    assign status_nxt = ((status_r & ~(wr_stat ? wr_bits : 32'h0000_0000))
                        | err_event_i) & UER_IMPL_MASK; // [RQ4] [RQ5] [RQ6] [RQ7] [RQ8] [RQ9] [RQ10] [RQ15]
    assign mask_nxt   = (wr_mask ? ((mask_r & ~wr_bmask) | wr_bits) : mask_r)
                        & UER_IMPL_MASK; // [RQ15]

    wire         new_report = |ev.report;
    wire         ptr_open   = ~ptr_valid_r | ~|(status_r & ev.mask ^ status_r);

    always_ff @(posedge sys_clk_i or negedge srst_sync_r) begin
        if (!srst_sync_r) begin
            status_r    <= UER_STATUS_RST;
            mask_r      <= UER_MASK_RST;
            first_ptr_r <= UER_PTR_RST;
            ptr_valid_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            mask_r   <= mask_nxt;
            // pointer rearms once every unmasked logged error has been cleared
            if (new_report && ptr_open) begin
                first_ptr_r <= uer_lowest_bit(ev.report); // [RQ16]
                ptr_valid_r <= 1'b1;
            end else if (~|(status_nxt & ~mask_nxt)) begin
                ptr_valid_r <= 1'b0;
            end
        end
    end

    logic [31:0] report_r;
    always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            report_r <= 32'h0000_0000;
        end else begin
            report_r <= ev.report; // [RQ11] [RQ12] [RQ13] [RQ14]
        end
    end
    assign err_report_o    = report_r;
    assign first_err_ptr_o = first_ptr_r;

    // ---------------------------------------------------------------
    // read channel
    // ---------------------------------------------------------------
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    wire [11:0]  rd_addr = {s_axi_araddr[11:2], 2'b00};
    wire [11:0]  next_ptr = downstream_i ? UER_NEXT_DOWN : UER_NEXT_UP; // [RQ3]
    wire [31:0]  hdr_word = {next_ptr, UER_CAP_VERSION, UER_CAP_ID}; // [RQ1] [RQ2] [RQ3]
    wire         rd_hit;
    wire [31:0]  rd_word;

    assign rd_hit  = (rd_addr == UER_OFS_HEADER) | (rd_addr == UER_OFS_STATUS)
                   | (rd_addr == UER_OFS_MASK) | (rd_addr == UER_OFS_FIRST_PTR);
    assign rd_word = (rd_addr == UER_OFS_HEADER)    ? hdr_word :
                     (rd_addr == UER_OFS_STATUS)    ? status_r :
                     (rd_addr == UER_OFS_MASK)      ? mask_r :
                     (rd_addr == UER_OFS_FIRST_PTR) ? {27'h0, first_ptr_r} :
                                                      32'h0000_0000;

    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= UER_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word;
            rresp_r  <= rd_hit ? UER_RESP_OKAY : UER_RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!srst_sync_r || !rst_sync_r);

    sequence s_rd_header;
        s_axi_arvalid && !rvalid_r && rd_addr == UER_OFS_HEADER;
    endsequence

    // write answer one edge after both halves are held
    sequence s_wr_pair;
        aw_have_r && w_have_r && !bvalid_r;
    endsequence

    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_hdr_id_read: assert property (s_rd_header |=> rdata_r[15:0] == 16'h0001) // [RQ1]
        else $error("capability id wrong");
    a_hdr_ver_read: assert property (s_rd_header |=> rdata_r[19:16] == 4'h1) // [RQ2]
        else $error("capability version wrong");
    a_hdr_next_read: assert property (s_rd_header |=> rdata_r[31:20] == // [RQ3]
        ($past(downstream_i) ? 12'h20c : 12'h140))
        else $error("next pointer wrong");
    a_train_set: assert property (err_event_i[0] |=> status_r[0]) // [RQ4]
        else $error("training status not set");
    a_dllp_set: assert property (err_event_i[4] |=> status_r[4]) // [RQ5]
        else $error("link protocol status not set");
    a_poison_set: assert property (err_event_i[12] |=> status_r[12]) // [RQ6]
        else $error("poisoned status not set");
    a_fcpe_set: assert property (err_event_i[13] |=> status_r[13]) // [RQ7]
        else $error("flow control status not set");
    a_cpl_set: assert property (|err_event_i[16:14] |=> // [RQ8]
        (status_r[16:14] & $past(err_event_i[16:14])) == $past(err_event_i[16:14]))
        else $error("completion status not set");
    a_ovf_malf_set: assert property (|err_event_i[18:17] |=> // [RQ9]
        (status_r[18:17] & $past(err_event_i[18:17])) == $past(err_event_i[18:17]))
        else $error("overflow or malformed status not set");
    a_ecrc_ur_set: assert property (|err_event_i[20:19] |=> // [RQ10]
        (status_r[20:19] & $past(err_event_i[20:19])) == $past(err_event_i[20:19]))
        else $error("crc or request status not set");
    a_mask_low: assert property (mask_r[0] |=> !err_report_o[0]) // [RQ11]
        else $error("masked training error reported");
    a_mask_mid: assert property (mask_r[13] |=> !err_report_o[13]) // [RQ12]
        else $error("masked flow control error reported");
    a_mask_cpl: assert property (mask_r[15] |=> !err_report_o[15]) // [RQ13]
        else $error("masked completer abort reported");
    a_mask_high: assert property (mask_r[20] |=> !err_report_o[20]) // [RQ14]
        else $error("masked request error reported");
    a_w1c_clear: assert property (wr_stat && wr_bits[4] && !err_event_i[4] // [RQ15]
        |=> !status_r[4])
        else $error("write one did not clear");
    a_rsvd_zero: assert property (((status_r | mask_r) & ~UER_IMPL_MASK) == 32'h0) // [RQ15]
        else $error("reserved bit set");
    a_ptr_first: assert property (!ptr_valid_r && ev.report == 32'h0000_1000 // [RQ16]
        |=> first_ptr_r == 5'h0c)
        else $error("first error pointer wrong");
    a_ptr_held: assert property (ptr_valid_r && |(status_r & ~mask_r) |=> // [RQ16]
        $stable(first_ptr_r))
        else $error("first error pointer moved");
    a_zero_no_clear: assert property (wr_stat && !wr_bits[12] && status_r[12] // [RQ15]
        |=> status_r[12])
        else $error("write zero cleared status");
    a_wr_answer: assert property (s_wr_pair |=> s_axi_bvalid)
        else $error("write response missing");
    a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read response missing");
    a_report_impl: assert property ((err_report_o & ~UER_IMPL_MASK) == 32'h0000_0000) // [RQ11]
        else $error("reserved class reported");
    a_mask_dllp: assert property (mask_r[4] |=> !err_report_o[4]) // [RQ11]
        else $error("masked link protocol error reported");
    a_mask_poison: assert property (mask_r[12] |=> !err_report_o[12]) // [RQ12]
        else $error("masked poisoned packet reported");
    a_mask_unexp: assert property (mask_r[16] |=> !err_report_o[16]) // [RQ13]
        else $error("masked unexpected completion reported");
    a_mask_ecrc: assert property (mask_r[19] |=> !err_report_o[19]) // [RQ14]
        else $error("masked crc error reported");
endmodule // uer_regs

// ==== tb/uer_rc_model.sv ====
// root complex stand-in: collects the error messages the port sends
module uer_rc_model (
    input  wire logic        sys_clk_i,
    input  wire logic        clr_i,
    input  wire logic [31:0] report_i,
    output logic      [31:0] seen_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // -----------------------------------------------
    // message capture
    // -----------------------------------------------
    // accumulate so a one-cycle strobe is never lost between bench polls
    always_ff @(posedge sys_clk_i) begin
        if (clr_i) begin
            seen_o <= 32'h0000_0000;
        end else begin
            seen_o <= seen_o | report_i;
        end
    end
endmodule // uer_rc_model

// ==== tb/aer_uncorrectable_error_regs_bench.sv ====
// testbench: register access, event logging, masking and sticky reset checks
module aer_uncorrectable_error_regs_bench
    import uer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_i = 1'b0, nrst_i = 1'b0, sticky_nrst_i = 1'b0, downstream_i = 1'b0;
    logic [31:0] err_event_i = 32'h0, err_report_o, seen, s_axi_wdata = 32'h0, s_axi_rdata;
    logic [4:0]  first_err_ptr_o;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, rc_clr = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [31:0] b;
    int          fail_count = 0;
    int          checks = 0;
    int          bits_q[11] = '{0, 4, 12, 13, 14, 15, 16, 17, 18, 19, 20};
    always #12.5 sys_clk_i = ~sys_clk_i;
    uer_regs DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .sticky_nrst_i(sticky_nrst_i),
        .downstream_i(downstream_i), .err_event_i(err_event_i), .err_report_o(err_report_o),
        .first_err_ptr_o(first_err_ptr_o), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1));
    uer_rc_model RC (.sys_clk_i(sys_clk_i), .clr_i(rc_clr), .report_i(err_report_o),
        .seen_o(seen));
    // -----------------------------------------------
    // helpers
    // -----------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // bready/rready tied high: legal, and avoids re-driving them each transfer
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end while (aw || w);
        do @(posedge sys_clk_i); while (s_axi_bvalid !== 1'b1);
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk_i); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk_i); while (s_axi_rvalid !== 1'b1);
        chk($sformatf("rdata %h", a), e, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask
    // one-cycle event pulse; the model is cleared on the same edge
    task automatic ev(input logic [31:0] v);
        rc_clr <= 1'b1;
        err_event_i <= v;
        @(posedge sys_clk_i);
        rc_clr <= 1'b0;
        err_event_i <= 32'h0;
        repeat (3) @(posedge sys_clk_i);
    endtask
    task automatic stop_test();
        if (fail_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        fail_count++;
        stop_test();
    end
    // -----------------------------------------------
    // tests
    // -----------------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        sticky_nrst_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        rd(12'h100, 32'h1401_0001, UER_RESP_OKAY);
        wr(12'h100, 32'hffff_ffff, UER_RESP_OKAY);
        rd(12'h100, 32'h1401_0001, UER_RESP_OKAY);
        rd(12'h104, 32'h0, UER_RESP_OKAY);
        rd(12'h108, 32'h0, UER_RESP_OKAY);
        for (int i = 0; i < 11; i++) begin
            b = 32'h1 << bits_q[i];
            ev(b);
            chk("message", b, seen);
            rd(12'h104, b, UER_RESP_OKAY);
            rd(12'h118, bits_q[i], UER_RESP_OKAY);
            chk("ptr pin", bits_q[i], {27'h0, first_err_ptr_o});
            wr(12'h104, ~b, UER_RESP_OKAY);
            rd(12'h104, b, UER_RESP_OKAY);
            wr(12'h104, b, UER_RESP_OKAY);
            rd(12'h104, 32'h0, UER_RESP_OKAY);
            wr(12'h108, b, UER_RESP_OKAY);
            ev(b);
            chk("masked message", 32'h0, seen);
            rd(12'h104, b, UER_RESP_OKAY);
            wr(12'h104, b, UER_RESP_OKAY);
            wr(12'h108, 32'h0, UER_RESP_OKAY);
        end
        // byte lanes: only lane 0 may reach the mask
        s_axi_wstrb <= 4'h1;
        wr(12'h108, 32'hffff_ffff, UER_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd(12'h108, 32'h0000_0011, UER_RESP_OKAY);
        // reserved bits and unmapped space
        wr(12'h108, 32'hffff_ffff, UER_RESP_OKAY);
        rd(12'h108, 32'h001f_f011, UER_RESP_OKAY);
        wr(12'h200, 32'hffff_ffff, UER_RESP_SLVERR);
        rd(12'h200, 32'h0, UER_RESP_SLVERR);
        ev(32'hffff_ffff);
        chk("all masked", 32'h0, seen);
        rd(12'h104, 32'h001f_f011, UER_RESP_OKAY);
        // bus reset alone must leave the sticky state
        nrst_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        rd(12'h104, 32'h001f_f011, UER_RESP_OKAY);
        rd(12'h108, 32'h001f_f011, UER_RESP_OKAY);
        sticky_nrst_i <= 1'b0;
        downstream_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        sticky_nrst_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        rd(12'h104, 32'h0, UER_RESP_OKAY);
        rd(12'h108, 32'h0, UER_RESP_OKAY);
        rd(12'h118, 32'h0, UER_RESP_OKAY);
        rd(12'h100, 32'h20c1_0001, UER_RESP_OKAY);
        stop_test();
    end
endmodule // aer_uncorrectable_error_regs_bench
